// >>> logic/lvm_limit_monitor.sv
// limit value monitor with hysteresis, delays and telegram output
`timescale 1ns/1ps
`default_nettype none
`include "lvm_params.svh"
module lvm_limit_monitor #(
  parameter int unsigned TICK_CYCLES = `LVM_TICK_CYCLES
) (
  input wire logic mclk, // system clock, 40 MHz
  input wire logic sys_rst, // async reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [`LVM_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic signed [15:0] meas_value, // measured value, 0.1 C
  input wire logic ext16_valid, // 2-byte object received
  input wire logic [15:0] ext16_value, // 2-byte threshold, 0.1 C
  input wire logic ext8_valid, // 1-byte object received
  input wire logic [7:0] ext8_value, // 1-byte threshold, percent of range
  input wire logic teach_valid, // switching object received
  input wire logic teach_bit, // switching object value
  output var lvm_pkg::lvm_tlg_s tlg, // limit telegram
  output logic limit_state // accepted limit state
);

  logic [31:0] ctrl_q;
  logic [31:0] timing_q;
  logic wr_en;
  logic rd_setup;
  logic download;
  logic tick;
  logic signed [15:0] ext_thr_q;
  logic ext_ok_q;
  logic teach_prev_q;
  logic raw_q;
  logic silent_q;
  logic acc_q;
  logic [11:0] tmr_q;
  logic [11:0] cyc_cnt_q;
  logic signed [15:0] cfg_thr;
  logic signed [15:0] act_thr;
  logic signed [16:0] hyst;
  logic signed [16:0] upper;
  logic signed [16:0] lower;
  logic above;
  logic below;
  logic [11:0] dly;
  logic accept;
  logic [11:0] period;
  logic cyc_fire;
  logic [17:0] pct_prod;
  logic [15:0] pct_thr;
  lvm_pkg::lvm_mode_s mode;
  lvm_pkg::lvm_src_e src;

  lvm_sec_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // crossing action table
  function automatic lvm_pkg::lvm_mode_s mode_decode(input logic [3:0] m);
    lvm_pkg::lvm_mode_s r;
    r.under_ref = m[1];
    r.hi = lvm_pkg::ACT_NONE;
    r.lo = lvm_pkg::ACT_NONE;
    case (m)
      4'h0:
      begin
        r.hi = lvm_pkg::ACT_ON;
        r.lo = lvm_pkg::ACT_OFF;
      end
      4'h1:
      begin
        r.hi = lvm_pkg::ACT_OFF;
        r.lo = lvm_pkg::ACT_ON;
      end
      4'h2:
      begin
        r.lo = lvm_pkg::ACT_ON;
        r.hi = lvm_pkg::ACT_OFF;
      end
      4'h3:
      begin
        r.lo = lvm_pkg::ACT_OFF;
        r.hi = lvm_pkg::ACT_ON;
      end
      4'h4: r.hi = lvm_pkg::ACT_ON;
      4'h5: r.hi = lvm_pkg::ACT_OFF;
      4'h6: r.lo = lvm_pkg::ACT_ON;
      4'h7: r.lo = lvm_pkg::ACT_OFF;
      4'h8: r.lo = lvm_pkg::ACT_OFF;
      4'h9: r.lo = lvm_pkg::ACT_ON;
      4'hA: r.hi = lvm_pkg::ACT_OFF;
      4'hB: r.hi = lvm_pkg::ACT_ON;
      default: r.under_ref = 1'b0;
    endcase
    return r;
  endfunction

  // configured threshold index to 0.1 C
  function automatic logic signed [15:0] thr_decode(input logic [5:0] i);
    logic signed [15:0] r;
    r = 16'sh01F4;
    case (i)
      6'h00: r = -16'sh0096;
      6'h01: r = -16'sh0064;
      6'h2B: r = 16'sh0190;
      6'h2C: r = 16'sh01C2;
      6'h2D: r = 16'sh01F4;
      default:
      begin
        if (i < 6'h2B)
          r = 16'(($signed({10'h000, i}) - 16'sh0007) * 16'sh000A);
      end
    endcase
    return r;
  endfunction

  // hysteresis index to 0.1 K
  function automatic logic signed [16:0] hyst_decode(input logic [3:0] i);
    logic signed [16:0] r;
    case (i)
      4'h0: r = 17'sh00000;
      4'h1: r = 17'sh0000A;
      4'h2: r = 17'sh00014;
      4'h3: r = 17'sh0001E;
      4'h4: r = 17'sh00028;
      4'h5: r = 17'sh00032;
      4'h6: r = 17'sh00064;
      4'h7: r = 17'sh00096;
      default: r = 17'sh000C8;
    endcase
    return r;
  endfunction

  // delay selection to seconds
  function automatic logic [11:0] delay_decode(input logic [3:0] i);
    logic [11:0] r;
    case (i)
      4'h0: r = 12'h000;
      4'h1: r = 12'h001;
      4'h2: r = 12'h003;
      4'h3: r = 12'h005;
      4'h4: r = 12'h00A;
      4'h5: r = 12'h00F;
      4'h6: r = 12'h01E;
      4'h7: r = 12'h03C;
      4'h8: r = 12'h0B4;
      4'h9: r = 12'h12C;
      4'hA: r = 12'h258;
      4'hB: r = 12'h384;
      4'hC: r = 12'h708;
      default: r = 12'hE10;
    endcase
    return r;
  endfunction

  // apb access
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign download = wr_en && (paddr == `LVM_OFS_CMD) && pwdata[`LVM_CMD_DOWNLOAD_BIT];

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= `LVM_CTRL_RST;
      timing_q <= `LVM_TIMING_RST;
    end
    else if (wr_en)
    begin
      if (paddr == `LVM_OFS_CTRL)
        ctrl_q <= pwdata & `LVM_CTRL_MASK;
      if (paddr == `LVM_OFS_TIMING)
        timing_q <= pwdata & `LVM_TIMING_MASK;
    end
  end

  // read data and error prepared in the setup cycle
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      case (paddr)
        `LVM_OFS_CTRL: prdata <= ctrl_q;
        `LVM_OFS_TIMING: prdata <= timing_q;
        `LVM_OFS_STATUS:
          prdata <= {act_thr, 10'h000, silent_q, ext_ok_q,
                     ~raw_q & acc_q, raw_q & ~acc_q, raw_q, acc_q};
        `LVM_OFS_CMD: prdata <= 32'h00000000;
        default: pslverr <= 1'b1;
      endcase
    end
  end

  assign mode = mode_decode(ctrl_q[`LVM_MODE_MSB:`LVM_MODE_LSB]);
  assign src = lvm_pkg::lvm_src_e'(ctrl_q[`LVM_SRC_MSB:`LVM_SRC_LSB]);
  assign cfg_thr = thr_decode(ctrl_q[`LVM_THR_MSB:`LVM_THR_LSB]);
  assign hyst = hyst_decode(ctrl_q[`LVM_HYST_MSB:`LVM_HYST_LSB]);

  // percent of range -20..55 C mapped to 0.1 C
  // both factors widened first so the product is not cut to the wider operand
  assign pct_prod = 18'(ext8_value) * 18'(`LVM_PCT_SPAN);
  assign pct_thr = 16'(`LVM_PCT_BASE + 16'(pct_prod / `LVM_PCT_FULL));

  // external threshold capture; a receipt outranks a download in the same cycle
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext_thr_q <= 16'sh0000;
      ext_ok_q <= 1'b0;
      teach_prev_q <= 1'b0;
    end
    else
    begin
      if (teach_valid)
        teach_prev_q <= teach_bit;
      if (download)
        ext_ok_q <= 1'b0;
      case (src)
        lvm_pkg::SRC_EXT16:
        begin
          if (ext16_valid)
          begin
            ext_thr_q <= $signed(ext16_value);
            ext_ok_q <= 1'b1;
          end
        end
        lvm_pkg::SRC_EXT8:
        begin
          if (ext8_valid)
          begin
            ext_thr_q <= $signed(pct_thr);
            ext_ok_q <= 1'b1;
          end
        end
        lvm_pkg::SRC_TEACH:
        begin
          if (teach_valid && teach_bit && !teach_prev_q)
          begin
            ext_thr_q <= meas_value;
            ext_ok_q <= 1'b1;
          end
        end
        default: ext_ok_q <= ext_ok_q & ~download;
      endcase
    end
  end

  assign act_thr = (src != lvm_pkg::SRC_CFG && ext_ok_q) ? ext_thr_q : cfg_thr;

  // band: over-referenced uses thr and thr-hyst, under-referenced thr and thr+hyst
  assign upper = mode.under_ref ? 17'(act_thr + hyst) : 17'(act_thr);
  assign lower = mode.under_ref ? 17'(act_thr) : 17'(act_thr - hyst);
  assign above = 17'(meas_value) > upper;
  assign below = 17'(meas_value) < lower;

  // raw comparison state and no-telegram condition
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      raw_q <= 1'b0;
      silent_q <= 1'b0;
    end
    else if (above)
    begin
      silent_q <= (mode.hi == lvm_pkg::ACT_NONE);
      if (mode.hi != lvm_pkg::ACT_NONE)
        raw_q <= (mode.hi == lvm_pkg::ACT_ON);
    end
    else if (below)
    begin
      silent_q <= (mode.lo == lvm_pkg::ACT_NONE);
      if (mode.lo != lvm_pkg::ACT_NONE)
        raw_q <= (mode.lo == lvm_pkg::ACT_ON);
    end
  end

  // switch-on and switch-off delays
  assign dly = raw_q ? delay_decode(timing_q[`LVM_ON_MSB:`LVM_ON_LSB])
                     : delay_decode(timing_q[`LVM_OFF_MSB:`LVM_OFF_LSB]);
  assign accept = (raw_q != acc_q) && (tmr_q >= dly);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_q <= 1'b0;
      tmr_q <= 12'h000;
    end
    else if (raw_q == acc_q)
      tmr_q <= 12'h000;
    else if (accept)
    begin
      acc_q <= raw_q;
      tmr_q <= 12'h000;
    end
    else if (tick)
      tmr_q <= tmr_q + 12'h001;
  end

  assign limit_state = acc_q;

  // cyclic repeat counter in seconds
  assign period = 12'(timing_q[`LVM_CYC_MSB:`LVM_CYC_LSB] * `LVM_CYC_STEP_S);
  assign cyc_fire = tick && (period != 12'h000) && (cyc_cnt_q + 12'h001 >= period);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      cyc_cnt_q <= 12'h000;
    else if (period == 12'h000)
      cyc_cnt_q <= 12'h000;
    else if (cyc_fire)
      cyc_cnt_q <= 12'h000;
    else if (tick)
      cyc_cnt_q <= cyc_cnt_q + 12'h001;
  end

  // telegram output
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      tlg <= '0;
    else
    begin
      tlg.send <= (accept && ctrl_q[`LVM_SOC_BIT])
                  || (cyc_fire && !silent_q);
      tlg.value <= accept ? raw_q : acc_q;
    end
  end

endmodule // lvm_limit_monitor
`default_nettype wire

// >>> logic/lvm_params.svh
// constants for the limit value monitor: offsets, fields, reset values, timing
//
// What this block does
// - mode 0: above threshold gives 1, below threshold minus hysteresis gives 0.
// - inverted mode: above threshold gives 0, below threshold minus hysteresis gives 1.
// - undershoot modes: below threshold gives 1 or 0, above threshold plus hysteresis opposite.
// - modes where one crossing sends nothing; twelve modes in total.
// - external 16-bit source takes the threshold from the received 2-byte object.
// - external 8-bit source takes the threshold from the received 1-byte object.
// - teach source captures the present measured value on a switching-object trigger.
// - a configuration download replaces any external threshold by the configured one.
// - after download an external threshold is used only once a new value arrives.
// - a 0-to-1 change is accepted and sent only after the switch-on delay.
// - cyclic sends keep sending 0 while the switch-on delay runs.
// - a 1-to-0 change is accepted and sent only after the switch-off delay.
// - cyclic sends keep sending 1 while the switch-off delay runs.
// - cyclic sends are suppressed while a no-telegram condition holds.
// - with send-on-change, every accepted state change is transmitted.
// - without send-on-change, a state change sends nothing.
// - cycle setting of at least 1 sends the object periodically regardless of change.
// - cyclic period in seconds is the cycle setting times ten.
// - cycle setting 0 disables cyclic sending.
// - no send-on-change and cycle 0 means the object is never sent.
// - configured threshold -15, -10, -5 to 35 in 1 degree steps, 40, 45, 50.
// - hysteresis none, 1 to 5 K, 10, 15 or 20 K.
`ifndef LVM_PARAMS_SVH
`define LVM_PARAMS_SVH

`define LVM_ADDR_W 12
`define LVM_OFS_CTRL 12'h000
`define LVM_OFS_TIMING 12'h004
`define LVM_OFS_STATUS 12'h008
`define LVM_OFS_CMD 12'h00C

`define LVM_MODE_LSB 0
`define LVM_MODE_MSB 3
`define LVM_HYST_LSB 4
`define LVM_HYST_MSB 7
`define LVM_THR_LSB 8
`define LVM_THR_MSB 13
`define LVM_SRC_LSB 14
`define LVM_SRC_MSB 15
`define LVM_SOC_BIT 16
`define LVM_CTRL_MASK 32'h0001FFFF

`define LVM_ON_LSB 0
`define LVM_ON_MSB 3
`define LVM_OFF_LSB 4
`define LVM_OFF_MSB 7
`define LVM_CYC_LSB 8
`define LVM_CYC_MSB 15
`define LVM_TIMING_MASK 32'h0000FFFF

`define LVM_CMD_DOWNLOAD_BIT 0

`define LVM_CTRL_RST 32'h00011B00
`define LVM_TIMING_RST 32'h00000000

`define LVM_CYC_STEP_S 12'h00A
`define LVM_PCT_BASE 16'hFF38
`define LVM_PCT_SPAN 10'h2EE
`define LVM_PCT_FULL 10'h0FF

`define LVM_CLK_PERIOD_NS 25
`define LVM_TICK_PERIOD_NS 1000000000
`define LVM_TICK_CYCLES (`LVM_TICK_PERIOD_NS / `LVM_CLK_PERIOD_NS)

`endif

// >>> logic/lvm_pkg.sv
// types shared by the limit value monitor
package lvm_pkg;

  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_ON,
    ACT_OFF
  } lvm_act_e;

  typedef enum logic [1:0] {
    SRC_CFG,
    SRC_EXT16,
    SRC_EXT8,
    SRC_TEACH
  } lvm_src_e;

  typedef struct packed {
    logic under_ref;
    lvm_act_e hi;
    lvm_act_e lo;
  } lvm_mode_s;

  typedef struct packed {
    logic send;
    logic value;
  } lvm_tlg_s;

endpackage

// >>> logic/lvm_sec_tick.sv
// one-second tick prescaler
`timescale 1ns/1ps
`default_nettype none
module lvm_sec_tick #(
  parameter int unsigned TICK_CYCLES = 40000000
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // async reset, high
  output logic tick // one-cycle pulse per second
);

  localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule // lvm_sec_tick
`default_nettype wire

// >>> verif/lvm_bus_model.sv
// bus partner: sends threshold objects, logs limit telegrams
`timescale 1ns/1ps
`default_nettype none
module lvm_bus_model (
  input wire logic mclk, // clock
  input wire lvm_pkg::lvm_tlg_s tlg, // telegram from monitor
  output logic ext16_valid, // 2-byte object strobe
  output logic [15:0] ext16_value, // 2-byte value
  output logic ext8_valid, // 1-byte object strobe
  output logic [7:0] ext8_value, // 1-byte value
  output logic teach_valid, // switching object strobe
  output logic teach_bit // switching object value
);
  int n_tlg = 0;
  int t_now = 0;
  int t_last = 0;
  int t_gap = 0;
  logic last_val = 1'b0;
  initial
  begin
    {ext16_valid, ext8_valid, teach_valid, teach_bit} = 4'h0;
    ext16_value = 16'h0;
    ext8_value = 8'h00;
  end
  always @(posedge mclk)
  begin
    t_now++;
    if (tlg.send === 1'b1)
    begin
      n_tlg++;
      last_val = tlg.value;
      t_gap = t_now - t_last;
      t_last = t_now;
    end
  end
  // released 2-byte and 1-byte value lines show the inverse, not the last value
  task automatic send16(input logic [15:0] v);
    @(posedge mclk);
    ext16_value <= v;
    ext16_valid <= 1'b1;
    @(posedge mclk);
    ext16_valid <= 1'b0;
    ext16_value <= ~v;
  endtask
  task automatic send8(input logic [7:0] v);
    @(posedge mclk);
    ext8_value <= v;
    ext8_valid <= 1'b1;
    @(posedge mclk);
    ext8_valid <= 1'b0;
    ext8_value <= ~v;
  endtask
  task automatic teach_rise;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk);
      teach_bit <= i[0];
      teach_valid <= 1'b1;
      @(posedge mclk);
      teach_valid <= 1'b0;
    end
  endtask
endmodule // lvm_bus_model
`default_nettype wire

// >>> verif/lvm_limit_monitor_checker.sv
// port assertions for the limit value monitor
`timescale 1ns/1ps
`default_nettype none
module lvm_limit_monitor_checker #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire lvm_pkg::lvm_tlg_s tlg, // telegram
  input wire logic limit_state // accepted state
);
  logic acc;
  logic soc_q;
  logic [7:0] cyc_q;
  assign acc = psel && penable && pready;
  // shadow of send-on-change and cycle setting
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      soc_q <= 1'b1;
      cyc_q <= 8'h00;
    end
    else if (acc && pwrite)
    begin
      if (paddr == 12'h000) soc_q <= pwdata[16];
      if (paddr == 12'h004) cyc_q <= pwdata[15:8];
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence chg_s;
    soc_q && (limit_state != $past(limit_state));
  endsequence
  sequence quiet_s;
    (!soc_q && cyc_q == 8'h00)[*3];
  endsequence
  ready_high_a: assert property (pready)
    else $error("pready low");
  unmapped_err_a: assert property (acc && paddr > 12'h00F |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && paddr[1:0] == 2'b00 && paddr <= 12'h00C |-> !pslverr)
    else $error("mapped access refused");
  cmd_zero_a: assert property (acc && !pwrite && paddr == 12'h00C |-> prdata == 32'h0)
    else $error("command register reads nonzero");
  status_acc_a: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata[0] == $past(limit_state))
    else $error("status state bit wrong");
  value_hold_a: assert property (soc_q && tlg.value != $past(tlg.value) |-> tlg.send)
    else $error("telegram value moved without send");
  send_value_a: assert property (tlg.send |-> tlg.value == limit_state)
    else $error("telegram value differs from state");
  change_send_a: assert property (chg_s |-> tlg.send)
    else $error("state change not sent");
  never_send_a: assert property (quiet_s |-> !tlg.send)
    else $error("telegram sent while sending is off");
endmodule // lvm_limit_monitor_checker
bind lvm_limit_monitor lvm_limit_monitor_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tlg(tlg), .limit_state(limit_state));
`default_nettype wire

// >>> verif/lvm_limit_monitor_tb.sv
// self-checking bench for the limit value monitor
`timescale 1ns/1ps
`default_nettype none
module lvm_limit_monitor_tb;
  localparam int TK = 10;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic signed [15:0] meas_value = 16'sd100;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext16_valid, ext8_valid, teach_valid, teach_bit, limit_state;
  logic [15:0] ext16_value;
  logic [7:0] ext8_value;
  lvm_pkg::lvm_tlg_s tlg;
  int fails = 0;
  int n_compared = 0;
  int c;
  int n;
  logic ex;
  logic [31:0] rv;
  logic re;
  lvm_limit_monitor #(.TICK_CYCLES(TK)) uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_value(meas_value), .ext16_valid(ext16_valid),
    .ext16_value(ext16_value), .ext8_valid(ext8_valid), .ext8_value(ext8_value),
    .teach_valid(teach_valid), .teach_bit(teach_bit), .tlg(tlg), .limit_state(limit_state));
  lvm_bus_model bus (.mclk(mclk), .tlg(tlg), .ext16_valid(ext16_valid),
    .ext16_value(ext16_value), .ext8_valid(ext8_valid), .ext8_value(ext8_value),
    .teach_valid(teach_valid), .teach_bit(teach_bit));
  initial
    forever #12.5 mclk = ~mclk;
  task automatic finish_test;
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk32({31'h0, g}, {31'h0, e});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
    begin
      fails++;
      finish_test;
    end
  endtask
  task automatic setm(input logic signed [15:0] v);
    @(posedge mclk);
    meas_value <= v;
    repeat (6) @(posedge mclk);
  endtask
  task automatic wait_state(input logic v, input int lim);
    for (int k = 0; k < lim && limit_state !== v; k++)
      @(posedge mclk);
    chk1(limit_state, v);
    if (limit_state !== v) finish_test;
  endtask
  task automatic thr(input logic [15:0] e);
    apb(1'b0, 12'h008, 32'h0);
    chk32({16'h0, rv[31:16]}, {16'h0, e});
  endtask
  task automatic act(input logic [1:0] a);
    if (a != 2'd2 && a[0] !== ex)
    begin
      ex = a[0];
      c++;
    end
  endtask
  task automatic t_regs;
    logic [5:0] ix [6];
    logic [15:0] tv [6];
    ix = '{0, 1, 2, 42, 43, 45};
    tv = '{16'hFF6A, 16'hFF9C, 16'hFFCE, 16'h015E, 16'h0190, 16'h01F4};
    apb(1'b0, 12'h000, 32'h0);
    chk32(rv, 32'h00011B00);
    apb(1'b0, 12'h004, 32'h0);
    chk32(rv, 32'h0);
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    apb(1'b0, 12'h000, 32'h0);
    chk32(rv, 32'h0001FFFF);
    apb(1'b0, 12'h040, 32'h0);
    chk1(re, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 12'h000, {18'h00004, ix[i], 8'h00});
      thr(tv[i]);
    end
    apb(1'b1, 12'h000, 32'h00011B00);
  endtask
  task automatic t_modes;
    logic [1:0] hi [12];
    logic [1:0] lo [12];
    int mv [6];
    logic ev [6];
    hi = '{1, 0, 0, 1, 1, 0, 2, 2, 2, 2, 0, 1};
    lo = '{0, 1, 1, 0, 2, 2, 1, 0, 0, 1, 2, 2};
    setm(16'sd300);
    ex = 1'b1;
    c = 0;
    n = bus.n_tlg;
    for (int m = 0; m < 12; m++)
    begin
      apb(1'b1, 12'h000, 32'h00011B00 | 32'(m));
      act(hi[m]);
      setm(16'sd100);
      act(lo[m]);
      chk1(limit_state, ex);
      setm(16'sd300);
      act(hi[m]);
      chk1(limit_state, ex);
    end
    chk32(bus.n_tlg - n, c);
    mv = '{190, 179, 200, 201, 221, 199};
    ev = '{1, 0, 0, 1, 0, 1};
    apb(1'b1, 12'h000, 32'h00011B20);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 4) apb(1'b1, 12'h000, 32'h00011B22);
      setm(16'(mv[i]));
      chk1(limit_state, ev[i]);
    end
  endtask
  task automatic t_delays;
    apb(1'b1, 12'h000, 32'h00011B00);
    setm(16'sd100);
    apb(1'b1, 12'h004, 32'h00000145);
    apb(1'b1, 12'h000, 32'h00011B00);
    n = bus.n_tlg;
    setm(16'sd300);
    repeat (12 * TK) @(posedge mclk);
    chk1(limit_state, 1'b0);
    chk1(bus.last_val, 1'b0);
    chk1(bus.n_tlg > n, 1'b1);
    wait_state(1'b1, 40);
    setm(16'sd100);
    repeat (8 * TK) @(posedge mclk);
    chk1(limit_state, 1'b1);
    chk1(bus.last_val, 1'b1);
    setm(16'sd300);
    repeat (12 * TK) @(posedge mclk);
    chk1(limit_state, 1'b1);
    setm(16'sd100);
    wait_state(1'b0, 12 * TK);
  endtask
  task automatic t_cyclic;
    apb(1'b1, 12'h000, 32'h00001B00);
    apb(1'b1, 12'h004, 32'h00000200);
    repeat (50 * TK) @(posedge mclk);
    chk32(bus.t_gap, 20 * TK);
    apb(1'b1, 12'h004, 32'h0);
    // let a cyclic send launched under the old period drain first
    repeat (3) @(posedge mclk);
    n = bus.n_tlg;
    setm(16'sd300);
    setm(16'sd100);
    chk1(bus.n_tlg == n, 1'b1);
    apb(1'b1, 12'h000, 32'h00001B04);
    apb(1'b1, 12'h004, 32'h00000100);
    repeat (25 * TK) @(posedge mclk);
    chk1(bus.n_tlg == n, 1'b1);
    setm(16'sd300);
    repeat (12 * TK) @(posedge mclk);
    chk1(bus.n_tlg > n, 1'b1);
  endtask
  task automatic t_ext;
    apb(1'b1, 12'h000, 32'h00015B00);
    bus.send8(8'h00);
    thr(16'h00C8);
    bus.send16(16'h0064);
    thr(16'h0064);
    apb(1'b1, 12'h00C, 32'h1);
    thr(16'h00C8);
    bus.send16(16'hFFEC);
    thr(16'hFFEC);
    apb(1'b1, 12'h000, 32'h00019B00);
    bus.send8(8'hFF);
    thr(16'h0226);
    bus.send8(8'h80);
    thr(16'h00B0);
    apb(1'b1, 12'h000, 32'h0001DB00);
    setm(16'sd123);
    bus.teach_rise();
    thr(16'h007B);
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_modes();
    t_delays();
    t_cyclic();
    t_ext();
    finish_test();
  end
endmodule // lvm_limit_monitor_tb
`default_nettype wire
